// ==== inc/bvs_pkg.sv ====
package bvs_pkg;

  // ------------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------------
  localparam logic [11:0] SW_CTL_OFS = 12'h000;
  localparam logic [11:0] BOOT_VECTOR_STATUS_OFS = 12'h004;

  // ------------------------------------------------------------------------
  // Switch control register fields
  // ------------------------------------------------------------------------
  localparam int CTL_RESET_HOLD_BIT = 2;
  localparam int CTL_BCAST_DROP_BIT = 19;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ------------------------------------------------------------------------
  // Boot vector status fields
  // ------------------------------------------------------------------------
  localparam int BVS_MODE_LSB = 0;
  localparam int BVS_MODE_W = 4;
  localparam int BVS_GCLK_BIT = 4;
  localparam int BVS_MADDR_LSB = 7;
  localparam int BVS_MADDR_W = 4;
  localparam int BVS_MSLOW_BIT = 11;
  localparam int BVS_SADDR_LSB = 12;
  localparam int BVS_SADDR_W = 4;
  localparam int BVS_HOLD_BIT = 16;
  localparam int BVS_CLOCKING_MODE_STRAP_LSB = 21;
  localparam int BVS_CLOCKING_MODE_STRAP_W = 3;
  localparam int BVS_MERGE_LSB = 24;
  localparam int BVS_MERGE_W = 8;

  // ------------------------------------------------------------------------
  // Message routing
  // ------------------------------------------------------------------------
  // Vendor-defined Type 1 message, routed as broadcast from root.
  localparam logic [7:0] TLP_TYPE_VDM1_BCAST = 8'h7B;
  localparam logic [1:0] FUND_RST_HOLD = 2'h3;

endpackage

// ==== verilog/bvs_top.sv ====
`timescale 1ns/1ps
// What this block does
// - With drop bit 19 set, upstream vendor Type 1 broadcasts are not forwarded.
// - A dropped message still returns its credits, is discarded, flags no error.
// - The drop bit is software read/write and resets to zero.
// - Boot vector status fields hold reset-sampled straps; writes never change them.
// - Bits 3:0 report the sampled switch mode strap.
// - Bit 4 reports the clock frequency strap; bits 6:5 read zero.
// - Bits 10:7 report master SMBus address bits 1 to 4.
// - Bit 11 reports the master SMBus slow mode strap.
// - Bits 15:12 report slave SMBus address bits 5, 1, 2, 3.
// - Bits 24 to 31 report the eight port-pair merge straps.
// - Reset hold control starts from its strap; holds the core after fundamental reset until cleared.
module bvs_top (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Fundamental reset level from the pad.
  input wire logic i_fund_rst,
  // Boot strap pins.
  input wire logic [3:0] i_switch_op_mode_strap,
  input wire logic i_global_clk_freq_strap,
  input wire logic [3:0] i_master_smbus_addr_strap,
  input wire logic i_master_smbus_slow_strap,
  input wire logic [3:0] i_slave_smbus_addr_strap,
  input wire logic i_reset_hold_strap,
  input wire logic [2:0] i_clocking_mode_strap,
  input wire logic [7:0] i_merge_pairs_strap,
  // Register port.
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Upstream received message stream.
  input wire logic i_msg_valid,
  input wire logic [7:0] i_msg_type,
  input wire logic [31:0] i_msg_data,
  input wire logic i_msg_last,
  // Downstream forward stream.
  output logic o_fwd_valid,
  output logic [31:0] o_fwd_data,
  output logic o_fwd_last,
  // Credit return for each consumed upstream word.
  output logic o_credit_ret,
  // Core hold during fundamental reset, and after it until halt is cleared.
  output logic o_core_hold
);

  // ------------------------------------------------------------------------
  // Strap and reset synchronisers
  // ------------------------------------------------------------------------
  localparam int SW = 26;
  logic [SW-1:0] strap_raw;
  logic [SW-1:0] strap_s1_q;
  logic [SW-1:0] strap_s2_q;
  logic [1:0] frst_sync_q;
  logic frst_s2;

  assign strap_raw = {i_merge_pairs_strap, i_clocking_mode_strap,
                      i_reset_hold_strap, i_slave_smbus_addr_strap,
                      i_master_smbus_slow_strap, i_master_smbus_addr_strap,
                      i_global_clk_freq_strap, i_switch_op_mode_strap};
  assign frst_s2 = frst_sync_q[1];

  // Two flops on every pad before anything looks at it.
  always_ff @(posedge i_clk_sys) begin
    strap_s1_q <= strap_raw;
    strap_s2_q <= strap_s1_q;
    frst_sync_q <= {frst_sync_q[0], i_fund_rst};
  end

  // ------------------------------------------------------------------------
  // Captured boot vector
  // ------------------------------------------------------------------------
  logic [SW-1:0] vec_q;
  logic [SW-1:0] vec_d;

  // Track straps while fundamental reset is asserted; freeze after release.
  assign vec_d = frst_s2 ? strap_s2_q : vec_q;

  // Register port writes never reach the vector.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      vec_q <= '0;
    end else begin
      vec_q <= vec_d;
    end
  end

  // Status word layout.
  logic [31:0] status_word;
  assign status_word[bvs_pkg::BVS_MODE_LSB +: bvs_pkg::BVS_MODE_W] =
    vec_q[3:0];
  assign status_word[bvs_pkg::BVS_GCLK_BIT] = vec_q[4];
  assign status_word[6:5] = 2'h0;
  assign status_word[bvs_pkg::BVS_MADDR_LSB +: bvs_pkg::BVS_MADDR_W] =
    vec_q[8:5];
  assign status_word[bvs_pkg::BVS_MSLOW_BIT] = vec_q[9];
  // Slave address strap order is address bits 5, 1, 2, 3 from the pins.
  assign status_word[bvs_pkg::BVS_SADDR_LSB +: bvs_pkg::BVS_SADDR_W] =
    vec_q[13:10];
  assign status_word[bvs_pkg::BVS_HOLD_BIT] = vec_q[14];
  assign status_word[20:17] = 4'h0;
  assign status_word[bvs_pkg::BVS_CLOCKING_MODE_STRAP_LSB +: bvs_pkg::BVS_CLOCKING_MODE_STRAP_W] =
    vec_q[17:15];
  assign status_word[bvs_pkg::BVS_MERGE_LSB +: bvs_pkg::BVS_MERGE_W] =
    vec_q[25:18];

  // ------------------------------------------------------------------------
  // Switch control register
  // ------------------------------------------------------------------------
  logic drop_q;
  logic drop_d;
  logic hold_q;
  logic hold_d;
  logic ctl_wr;
  logic frst_fall_q;
  logic [31:0] ctl_word;

  assign ctl_wr = i_wr && (i_addr == bvs_pkg::SW_CTL_OFS);
  assign drop_d = ctl_wr ? i_wdata[bvs_pkg::CTL_BCAST_DROP_BIT] : drop_q;
  // While fundamental reset is held the halt bit follows its strap.
  assign hold_d = frst_s2 ? strap_s2_q[14] :
                  ctl_wr ? i_wdata[bvs_pkg::CTL_RESET_HOLD_BIT] : hold_q;

  // Drop bit resets to forward; halt bit resets to zero and is loaded from the strap.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      drop_q <= bvs_pkg::CTL_RESET[bvs_pkg::CTL_BCAST_DROP_BIT];
      hold_q <= bvs_pkg::CTL_RESET[bvs_pkg::CTL_RESET_HOLD_BIT];
    end else begin
      drop_q <= drop_d;
      hold_q <= hold_d;
    end
  end

  // Only the implemented bits appear; all others read zero.
  always_comb begin
    ctl_word = '0;
    ctl_word[bvs_pkg::CTL_BCAST_DROP_BIT] = drop_q;
    ctl_word[bvs_pkg::CTL_RESET_HOLD_BIT] = hold_q;
  end

  // Fundamental reset sequence: core stays held until the halt bit clears.
  logic core_hold_d;
  logic core_hold_q;
  assign core_hold_d = frst_s2 || (core_hold_q && hold_q);

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      core_hold_q <= 1'b1;
      frst_fall_q <= 1'b0;
    end else begin
      core_hold_q <= core_hold_d;
      frst_fall_q <= frst_s2;
    end
  end

  // ------------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------------
  logic [31:0] rdata_d;
  assign rdata_d = !i_rd ? 32'h0000_0000 :
    (i_addr == bvs_pkg::SW_CTL_OFS) ? ctl_word :
    (i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS) ? status_word :
    32'h0000_0000;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  // ------------------------------------------------------------------------
  // Upstream broadcast filter
  // ------------------------------------------------------------------------
  logic in_drop_q;
  logic in_drop_d;
  logic in_sop_q;
  logic word_drop;
  logic is_bcast;

  // Decision is made on the first word and held across the message.
  assign is_bcast = (i_msg_type == bvs_pkg::TLP_TYPE_VDM1_BCAST);
  assign word_drop = in_sop_q ? (drop_q && is_bcast) : in_drop_q;
  assign in_drop_d = (i_msg_valid && in_sop_q) ? word_drop : in_drop_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      in_sop_q <= 1'b1;
      in_drop_q <= 1'b0;
    end else begin
      in_drop_q <= in_drop_d;
      if (i_msg_valid) begin
        in_sop_q <= i_msg_last;
      end
    end
  end

  // Dropped words never reach downstream; credits return regardless.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_fwd_valid <= 1'b0;
      o_fwd_data <= '0;
      o_fwd_last <= 1'b0;
      o_credit_ret <= 1'b0;
    end else begin
      o_fwd_valid <= i_msg_valid && !word_drop;
      o_fwd_data <= word_drop ? '0 : i_msg_data;
      o_fwd_last <= i_msg_valid && !word_drop && i_msg_last;
      o_credit_ret <= i_msg_valid;
    end
  end

  assign o_core_hold = core_hold_q;

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  AST_DROP_NO_FWD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_msg_valid && in_sop_q && is_bcast && drop_q) |=> !o_fwd_valid)
    else $error("Dropped broadcast was forwarded.");

  AST_CREDIT_RET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_msg_valid |=> o_credit_ret)
    else $error("Credit not returned for a consumed word.");

  AST_DROP_RESET: assert property (@(posedge i_clk_sys)
    i_srst |=> !drop_q)
    else $error("Drop bit not cleared by reset.");

  AST_VEC_STABLE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!frst_s2 && !$past(frst_s2)) |-> $stable(vec_q))
    else $error("Boot vector changed outside fundamental reset.");

  AST_MODE_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS && !frst_s2)
    |=> o_rdata[3:0] == vec_q[3:0] && o_rdata[6:5] == 2'h0)
    else $error("Mode field or zero bits read wrong.");

  AST_MERGE_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS && !frst_s2)
    |=> o_rdata[31:24] == vec_q[25:18])
    else $error("Merge straps read wrong.");

  AST_SADDR_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS && !frst_s2)
    |=> o_rdata[15:7] == vec_q[13:5])
    else $error("SMBus straps read wrong.");

  AST_CTL_RSVD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::SW_CTL_OFS)
    |=> o_rdata[31:20] == 12'h000)
    else $error("Reserved control bits not zero.");

  AST_HOLD_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    frst_s2 |=> hold_q == $past(strap_s2_q[14]))
    else $error("Halt bit not loaded from strap.");

  AST_HOLD_CORE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (frst_fall_q && !frst_s2 && hold_q && core_hold_q) |=> o_core_hold)
    else $error("Core released while halt bit set.");

  // Single-bit status fields and the clock mode field read back as captured.
  AST_FLAG_READ: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS && !frst_s2)
    |=> o_rdata[4] == vec_q[4] && o_rdata[11] == vec_q[9]
    && o_rdata[16] == vec_q[14] && o_rdata[23:21] == vec_q[17:15])
    else $error("Single-bit or clock mode strap read wrong.");

  AST_STS_RSVD: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_rd && i_addr == bvs_pkg::BOOT_VECTOR_STATUS_OFS)
    |=> o_rdata[20:17] == 4'h0)
    else $error("Reserved status bits not zero.");

  AST_RDATA_IDLE: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("Read data not zero outside a read.");

  AST_DROP_WRITE: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    ctl_wr |=> drop_q == $past(i_wdata[bvs_pkg::CTL_BCAST_DROP_BIT]))
    else $error("Drop bit did not take the written value.");

  AST_FWD_PASS: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_msg_valid && !word_drop)
    |=> o_fwd_valid && o_fwd_data == $past(i_msg_data))
    else $error("Kept word was not forwarded intact.");

  AST_DROP_DATA: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    (i_msg_valid && word_drop)
    |=> !o_fwd_valid && !o_fwd_last && o_fwd_data == 32'h0000_0000)
    else $error("Dropped word contents leaked downstream.");

  AST_HOLD_FRST: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    frst_s2 |=> o_core_hold)
    else $error("Core not held during fundamental reset.");

endmodule

// ==== bench/bvs_far_model.sv ====
`timescale 1ns/1ps
// Far side: strap pins, fundamental reset pad and upstream message link.
module bvs_far_model (
  // Clock.
  input wire logic i_clk_sys,
  // Pad and strap levels, packed in status layout.
  output logic o_fund_rst,
  output logic [31:0] o_straps,
  // Upstream received words.
  output logic o_msg_valid,
  output logic [7:0] o_msg_type,
  output logic [31:0] o_msg_data,
  output logic o_msg_last
);
  // Idle levels at time zero.
  initial begin
    o_fund_rst = 1'b0;
    o_straps = 32'h0000_0000;
    o_msg_valid = 1'b0;
    o_msg_type = 8'h00;
    o_msg_data = 32'h0000_0000;
    o_msg_last = 1'b0;
  end

  // Pulses fundamental reset, then moves the straps to prove they froze.
  task automatic fund_cycle(input logic [31:0] s);
    @(posedge i_clk_sys);
    o_straps <= s;
    o_fund_rst <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    o_fund_rst <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_straps <= ~s;
  endtask

  // Drives one word; an idle link shows inverted junk, not old data.
  task automatic word(input logic v, input logic [7:0] t,
                      input logic [31:0] d, input logic l);
    o_msg_valid <= v;
    o_msg_type <= v ? t : ~o_msg_type;
    o_msg_data <= v ? d : ~o_msg_data;
    o_msg_last <= v ? l : 1'b0;
  endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  localparam logic [31:0] MASK = 32'hFFE1_FF9F;
  localparam logic [11:0] CTL = bvs_pkg::SW_CTL_OFS;
  localparam logic [11:0] STS = bvs_pkg::BOOT_VECTOR_STATUS_OFS;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, straps, md, fdata;
  logic [7:0] mt;
  logic fund, mv, ml, fv, fl, cred, hold;
  logic [31:0] pat [2] = '{32'hFFFF_FFFF, 32'h5A4E_A815};
  int error_cnt = 0;
  int tests_run = 0;

  // Clock generator.
  always #5 clk = ~clk;

  bvs_far_model u_far (.i_clk_sys(clk), .o_fund_rst(fund), .o_straps(straps),
    .o_msg_valid(mv), .o_msg_type(mt), .o_msg_data(md), .o_msg_last(ml));

  bvs_top u_dut (.i_clk_sys(clk), .i_srst(srst), .i_fund_rst(fund),
    .i_switch_op_mode_strap(straps[3:0]),
    .i_global_clk_freq_strap(straps[4]),
    .i_master_smbus_addr_strap(straps[10:7]),
    .i_master_smbus_slow_strap(straps[11]),
    .i_slave_smbus_addr_strap(straps[15:12]),
    .i_reset_hold_strap(straps[16]),
    .i_clocking_mode_strap(straps[23:21]),
    .i_merge_pairs_strap(straps[31:24]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata),
    .i_msg_valid(mv), .i_msg_type(mt), .i_msg_data(md), .i_msg_last(ml),
    .o_fwd_valid(fv), .o_fwd_data(fdata), .o_fwd_last(fl),
    .o_credit_ret(cred), .o_core_hold(hold));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single-cycle register write.
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Register read; data is sampled in the cycle after the strobe.
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Sends n back-to-back words and checks each word one cycle later.
  task automatic msg(input logic [7:0] t, input int n, input logic drop);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      u_far.word(i < n, t, 32'h1000_0000 + i, i == n - 1);
      #1 if (i > 0) begin
        chk(cred, 1'b1);
        chk(fv, !drop);
        if (!drop) begin
          chk(fdata, 32'h1000_0000 + i - 1);
          chk(fl, i == n);
        end
      end
    end
  endtask

  // Prints counts and verdict, then ends the run.
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  // Main sequence.
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd_reg(CTL, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      u_far.fund_cycle(pat[k]);
      rd_reg(STS, pat[k] & MASK);
      wr_reg(STS, ~pat[k]);
      rd_reg(STS, pat[k] & MASK);
      rd_reg(CTL, {29'h0, pat[k][16], 2'h0});
      chk(hold, pat[k][16]);
      wr_reg(CTL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      chk(hold, 1'b0);
    end
    wr_reg(CTL, 32'hFFFF_FFFF);
    rd_reg(CTL, 32'h0008_0004);
    rd_reg(12'h010, 32'h0000_0000);
    msg(bvs_pkg::TLP_TYPE_VDM1_BCAST, 2, 1'b1);
    msg(8'h70, 2, 1'b0);
    wr_reg(CTL, 32'h0000_0000);
    msg(bvs_pkg::TLP_TYPE_VDM1_BCAST, 1, 1'b0);
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
